// ---- enc_scaler.sv ----
// quadrature decoder that scales encoder counts to motor microsteps
`timescale 1ns/1ps
`default_nettype none

module enc_scaler
  import stepper_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire enc_pins_t   pins,
  input  wire logic [23:0] msteps_rev,
  input  wire logic [15:0] enc_res,
  input  wire logic        clr_on_index,
  input  wire logic        ref_clr,
  input  wire logic        wr_pos,
  input  wire logic [31:0] wr_val,
  output logic      [31:0] pos,
  output logic             index_hit
);

  logic        a_p_r;
  logic        b_p_r;
  logic        n_p_r;
  logic [27:0] acc_r;
  logic [27:0] acc_nxt;
  logic [31:0] pos_r;
  logic [31:0] pos_nxt;

  // ==========================================================
  // quadrature step detection: one edge per clock at most
  wire        moved = (pins.a ^ a_p_r) ^ (pins.b ^ b_p_r);
  wire        dir_dn = a_p_r ^ pins.b;
  wire [27:0] m_ext = {4'h0, msteps_rev};
  wire [27:0] e_ext = {12'h000, enc_res};
  wire [27:0] acc_add = !moved ? acc_r : (dir_dn ? acc_r - m_ext : acc_r + m_ext);
  wire        go_up = (enc_res != 16'h0000) && !acc_add[27] && (acc_add >= e_ext);
  wire        go_dn = (enc_res != 16'h0000) && acc_add[27] && ((28'h000_0000 - acc_add) >= e_ext);

  assign index_hit = pins.n && !n_p_r;

  // remainder drains one microstep per clock, slower than encoder edges less than msteps_rev/enc_res clocks apart
  always_comb begin
    acc_nxt = acc_add;
    pos_nxt = pos_r;
    if (go_up) begin
      acc_nxt = acc_add - e_ext;
      pos_nxt = pos_r + 32'h0000_0001;
    end else if (go_dn) begin
      acc_nxt = acc_add + e_ext;
      pos_nxt = pos_r - 32'h0000_0001;
    end
    if (wr_pos) begin
      acc_nxt = 28'h000_0000;
      pos_nxt = wr_val;
    end else if (ref_clr || (clr_on_index && index_hit)) begin
      acc_nxt = 28'h000_0000;
      pos_nxt = 32'h0000_0000;
    end
  end

  // position and remainder registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      a_p_r <= 1'b0;
      b_p_r <= 1'b0;
      n_p_r <= 1'b0;
      acc_r <= 28'h000_0000;
      pos_r <= 32'h0000_0000;
    end else begin
      a_p_r <= pins.a;
      b_p_r <= pins.b;
      n_p_r <= pins.n;
      acc_r <= acc_nxt;
      pos_r <= pos_nxt;
    end
  end

  assign pos = pos_r;

endmodule

`default_nettype wire

// ---- quad_enc_model.sv ----
// encoder model: quadrature phases and index channel seen by the supervisor
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// encoder model
module quad_enc_model
  import stepper_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      fwd,
  input  wire logic      idx,
  output var  enc_pins_t pins
);
  logic [1:0] ph_r = 2'h0;
  logic       n_r  = 1'b0;

  // one gray step forward per fwd cycle, index follows idx
  always_ff @(posedge mclk) begin
    if (fwd) ph_r <= ph_r + 2'h1;
    n_r <= idx;
  end

  // phase order 00,10,11,01 counts up
  assign pins = '{ph_r[0] ^ ph_r[1], ph_r[1], n_r};
endmodule
`default_nettype wire

// ---- stepper_load_current_supervisor.sv ----
// stepper axis supervisor: encoder scaling, stall and deviation stop, adaptive current
//
// The implementer's own choices: the register addresses and strobed register access.
`include "stepper_params.svh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// - encoder counts scaled by full steps, microsteps and encoder resolution to microsteps.
// - full steps per revolution reset to 200.
// - encoder position read and written by software, zeroed on reference done.
// - deviation beyond configured limit stops motor when the limit is nonzero.
// - encoder function bit clears position on index channel rising edge.
// - load value falls linearly with measured lag, zero at maximum load.
// - load value zero above stall stop speed stops motor; never below it.
// - adaptive current regulation only above its threshold speed.
// - maximum current 0..255 quantised into 32 steps of eight codes.
// - after standstill wait delay in 10 ms units, then standby current.
// - minimum setting 0 gives half, 1 gives quarter of current scale.
// - down code 0..3 needs 32, 8, 2 or 1 high readings per decrement.
// - each reading below lower threshold raises current by 1, 2, 4 or 8.
// - upper threshold is lower threshold plus hysteresis; above it current falls.
// - unit mode 1 uses microsteps per second speed, 0 uses internal units.
// - microstep setting is a power of two exponent, default 8 for 256.
module stepper_load_current_supervisor
  import stepper_pkg::*;
#(
  parameter logic [31:0] PD_UNIT_CYCLES = 32'(`PD_UNIT_CYCLES)
)
(
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire regbus_req_t   bus,
  output logic        [31:0] rdata,
  input  wire enc_pins_t     enc,
  input  wire logic   [31:0] motor_pos,
  input  wire logic   [31:0] vel_pps,
  input  wire logic   [31:0] vel_int,
  input  wire logic   [9:0]  load_lag,
  input  wire logic          load_valid,
  input  wire logic          ref_done,
  output logic               stop_req,
  output logic        [4:0]  motor_cs,
  output logic               standby_active,
  output logic               irq
);

  // ==========================================================
  // helper functions
  function automatic logic [31:0] mag32(input logic [31:0] v);
    mag32 = v[31] ? (32'h0000_0000 - v) : v;
  endfunction

  function automatic logic [5:0] down_need(input logic [1:0] code);
    case (code)
      2'h0:    down_need = 6'h20;
      2'h1:    down_need = 6'h08;
      2'h2:    down_need = 6'h02;
      default: down_need = 6'h01;
    endcase
  endfunction

  // ==========================================================
  // configuration registers
  logic [7:0]          max_cur_r;
  logic [7:0]          stby_cur_r;
  logic [3:0]          mstep_res_r;
  logic                adapt_min_r;
  logic [1:0]          down_code_r;
  logic [1:0]          up_code_r;
  logic [9:0]          hyst_r;
  logic [9:0]          lower_r;
  logic [31:0]         stall_speed_r;
  logic [31:0]         adapt_speed_r;
  logic [7:0]          enc_func_r;
  logic [15:0]         fullsteps_r;
  logic [15:0]         enc_res_r;
  logic [31:0]         max_dev_r;
  logic [15:0]         pd_delay_r;
  logic                unit_mode_r;
  logic [`ST_W-1:0]    status_r;
  logic [`ST_W-1:0]    mask_r;

  // state and outputs
  logic [9:0]          load_val_r;
  logic                load_new_r;
  logic [4:0]          cur_r;
  logic [4:0]          cur_nxt;
  logic [5:0]          down_cnt_r;
  logic [5:0]          down_cnt_nxt;
  power_state_t        ps_r;
  power_state_t        ps_nxt;
  logic [31:0]         tick_r;
  logic [15:0]         pd_units_r;
  logic [31:0]         rdata_r;
  logic                stop_req_r;
  logic [4:0]          motor_cs_r;
  logic                irq_r;
  logic                standby_r;
  logic [31:0]         enc_pos;
  logic                index_hit;

  // ==========================================================
  // register decode
  wire wr_hit = bus.wr;
  wire wr_pos_w = wr_hit && (bus.addr == `ADDR_ENC_POS);
  wire wr_status = wr_hit && (bus.addr == `ADDR_STATUS);

  // microsteps per revolution; resolution code clamps at 256 microsteps
  wire [3:0]  res_eff = (mstep_res_r > `MSTEP_RES_MAX) ? `MSTEP_RES_MAX : mstep_res_r;
  wire [23:0] msteps_rev = {8'h00, fullsteps_r} << res_eff;

  // speed in the selected unit system
  wire [31:0] speed = unit_mode_r ? mag32(vel_pps) : mag32(vel_int);
  wire        fast_stall = (stall_speed_r != 32'h0000_0000) && (speed > stall_speed_r);
  wire        fast_adapt = speed > adapt_speed_r;
  wire        moving = speed != 32'h0000_0000;

  // following error between encoder and motor counter
  wire [32:0] pos_diff = {enc_pos[31], enc_pos} - {motor_pos[31], motor_pos};
  wire [32:0] dev_mag = pos_diff[32] ? (33'h0_0000_0000 - pos_diff) : pos_diff;
  wire        dev_exceed = (max_dev_r != 32'h0000_0000) && (dev_mag > {1'b0, max_dev_r});

  // load value: linear fall with lag, zero at maximum load
  wire [9:0]  load_calc = (load_lag >= `LOAD_MAX) ? 10'h000 : (`LOAD_MAX - load_lag);

  // current window
  wire [4:0]  cs_w = max_cur_r[7:3];
  wire [4:0]  min_w = adapt_min_r ? {2'b00, cs_w[4:2]} : {1'b0, cs_w[4:1]};
  wire [10:0] upper_w = {1'b0, lower_r} + {1'b0, hyst_r};
  wire        below_lo = load_val_r < lower_r;
  wire        above_hi = {1'b0, load_val_r} > upper_w;
  wire [5:0]  up_w = 6'h01 << up_code_r;
  wire [5:0]  cur_up = {1'b0, cur_r} + up_w;
  wire [5:0]  need_w = down_need(down_code_r);

  // sticky status events
  wire [`ST_W-1:0] ev;
  assign ev[`ST_STALL] = load_new_r && (load_val_r == 10'h000) && fast_stall;
  assign ev[`ST_DEV] = dev_exceed;
  assign ev[`ST_INDEX] = index_hit;
  assign ev[`ST_REFCLR] = ref_done;
  assign ev[`ST_STANDBY] = (ps_r != PS_STANDBY) && (ps_nxt == PS_STANDBY);
  wire [`ST_W-1:0] clr_bits = wr_status ? bus.wdata[`ST_W-1:0] : {`ST_W{1'b0}};
  wire [`ST_W-1:0] status_nxt = (status_r & ~clr_bits) | ev;
  wire [`ST_W-1:0] stop_bits = (`ST_W'(1) << `ST_STALL) | (`ST_W'(1) << `ST_DEV);

  // read mux; unmapped addresses read zero
  wire [31:0] rd_mux =
    (bus.addr == `ADDR_MAX_CURRENT)     ? {24'h00_0000, max_cur_r} :
    (bus.addr == `ADDR_STANDBY_CURRENT) ? {24'h00_0000, stby_cur_r} :
    (bus.addr == `ADDR_MSTEP_RES)       ? {28'h000_0000, mstep_res_r} :
    (bus.addr == `ADDR_ADAPT_MIN)       ? {31'h0000_0000, adapt_min_r} :
    (bus.addr == `ADDR_DOWN_STEP)       ? {30'h0000_0000, down_code_r} :
    (bus.addr == `ADDR_HYST)            ? {22'h00_0000, hyst_r} :
    (bus.addr == `ADDR_UP_STEP)         ? {30'h0000_0000, up_code_r} :
    (bus.addr == `ADDR_STALL_SPEED)     ? stall_speed_r :
    (bus.addr == `ADDR_ADAPT_SPEED)     ? adapt_speed_r :
    (bus.addr == `ADDR_ENC_FUNC)        ? {24'h00_0000, enc_func_r} :
    (bus.addr == `ADDR_FULLSTEPS)       ? {16'h0000, fullsteps_r} :
    (bus.addr == `ADDR_ENC_POS)         ? enc_pos :
    (bus.addr == `ADDR_ENC_RES)         ? {16'h0000, enc_res_r} :
    (bus.addr == `ADDR_MAX_DEV)         ? max_dev_r :
    (bus.addr == `ADDR_PD_DELAY)        ? {16'h0000, pd_delay_r} :
    (bus.addr == `ADDR_LOAD_LOWER)      ? {22'h00_0000, lower_r} :
    (bus.addr == `ADDR_STATUS)          ? {27'h000_0000, status_r} :
    (bus.addr == `ADDR_MASK)            ? {27'h000_0000, mask_r} :
    (bus.addr == `ADDR_LOAD_VALUE)      ? {22'h00_0000, load_val_r} :
    (bus.addr == `ADDR_CUR_SCALE)       ? {27'h000_0000, motor_cs_r} :
    (bus.addr == `ADDR_UNIT_MODE)       ? {31'h0000_0000, unit_mode_r} :
    32'h0000_0000;

  // ==========================================================
  // encoder scaling
  enc_scaler i_enc_scaler (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .pins         (enc),
    .msteps_rev   (msteps_rev),
    .enc_res      (enc_res_r),
    .clr_on_index (enc_func_r[`ENC_FUNC_CLR_INDEX]),
    .ref_clr      (ref_done),
    .wr_pos       (wr_pos_w),
    .wr_val       (bus.wdata),
    .pos          (enc_pos),
    .index_hit    (index_hit)
  );

  // ==========================================================
  // configuration writes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      max_cur_r     <= `MAX_CURRENT_RST;
      stby_cur_r    <= `STANDBY_CURRENT_RST;
      mstep_res_r   <= `MSTEP_RES_RST;
      adapt_min_r   <= 1'b0;
      down_code_r   <= 2'h0;
      up_code_r     <= 2'h0;
      hyst_r        <= 10'h000;
      lower_r       <= 10'h000;
      stall_speed_r <= 32'h0000_0000;
      adapt_speed_r <= 32'h0000_0000;
      enc_func_r    <= 8'h00;
      fullsteps_r   <= `FULLSTEPS_RST;
      enc_res_r     <= `ENC_RES_RST;
      max_dev_r     <= 32'h0000_0000;
      pd_delay_r    <= `PD_DELAY_RST;
      unit_mode_r   <= `UNIT_MODE_RST;
      mask_r        <= {`ST_W{1'b0}};
    end else if (wr_hit) begin
      case (bus.addr)
        `ADDR_MAX_CURRENT:     max_cur_r <= bus.wdata[7:0];
        `ADDR_STANDBY_CURRENT: stby_cur_r <= bus.wdata[7:0];
        `ADDR_MSTEP_RES:       mstep_res_r <= bus.wdata[3:0];
        `ADDR_ADAPT_MIN:       adapt_min_r <= bus.wdata[0];
        `ADDR_DOWN_STEP:       down_code_r <= bus.wdata[1:0];
        `ADDR_HYST:            hyst_r <= bus.wdata[9:0];
        `ADDR_UP_STEP:         up_code_r <= bus.wdata[1:0];
        `ADDR_STALL_SPEED:     stall_speed_r <= bus.wdata;
        `ADDR_ADAPT_SPEED:     adapt_speed_r <= bus.wdata;
        `ADDR_ENC_FUNC:        enc_func_r <= bus.wdata[7:0];
        `ADDR_FULLSTEPS:       fullsteps_r <= bus.wdata[15:0];
        `ADDR_ENC_RES:         enc_res_r <= bus.wdata[15:0];
        `ADDR_MAX_DEV:         max_dev_r <= bus.wdata;
        `ADDR_PD_DELAY:        pd_delay_r <= bus.wdata[15:0];
        `ADDR_LOAD_LOWER:      lower_r <= bus.wdata[9:0];
        `ADDR_MASK:            mask_r <= bus.wdata[`ST_W-1:0];
        `ADDR_UNIT_MODE:       unit_mode_r <= bus.wdata[0];
        default:               max_cur_r <= max_cur_r;
      endcase
    end
  end

  // ==========================================================
  // adaptive current: raise on low load value, lower after enough high readings
  always_comb begin
    cur_nxt = cur_r;
    down_cnt_nxt = down_cnt_r;
    if (!fast_adapt) begin
      cur_nxt = cs_w;
      down_cnt_nxt = 6'h00;
    end else if (load_new_r && below_lo) begin
      cur_nxt = (cur_up > {1'b0, cs_w}) ? cs_w : cur_up[4:0];
      down_cnt_nxt = 6'h00;
    end else if (load_new_r && above_hi) begin
      if ((down_cnt_r + 6'h01) >= need_w) begin
        cur_nxt = (cur_r > min_w) ? (cur_r - 5'h01) : min_w;
        down_cnt_nxt = 6'h00;
      end else begin
        down_cnt_nxt = down_cnt_r + 6'h01;
      end
    end
    if (cur_nxt > cs_w) begin
      cur_nxt = cs_w;
    end else if (cur_nxt < min_w) begin
      cur_nxt = min_w;
    end
  end

  // ==========================================================
  // power state: standstill delay before standby current
  wire tick_end = tick_r >= (PD_UNIT_CYCLES - 32'h0000_0001);
  always_comb begin
    case (ps_r)
      PS_RUN:     ps_nxt = moving ? PS_RUN : PS_WAIT;
      PS_WAIT:    ps_nxt = moving ? PS_RUN :
                           ((pd_units_r >= pd_delay_r) ? PS_STANDBY : PS_WAIT);
      PS_STANDBY: ps_nxt = moving ? PS_RUN : PS_STANDBY;
      default:    ps_nxt = PS_RUN;
    endcase
  end

  // standstill timer counts whole 10 ms units
  always_ff @(posedge mclk) begin
    if (!rst_n || ps_r != PS_WAIT) begin
      tick_r     <= 32'h0000_0000;
      pd_units_r <= 16'h0000;
    end else if (tick_end) begin
      tick_r     <= 32'h0000_0000;
      pd_units_r <= pd_units_r + 16'h0001;
    end else begin
      tick_r     <= tick_r + 32'h0000_0001;
    end
  end

  // ==========================================================
  // load, regulator, status and output registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      load_val_r     <= `LOAD_MAX;
      load_new_r     <= 1'b0;
      cur_r          <= 5'(`MAX_CURRENT_RST >> 3);
      down_cnt_r     <= 6'h00;
      ps_r           <= PS_RUN;
      status_r       <= {`ST_W{1'b0}};
      stop_req_r     <= 1'b0;
      motor_cs_r     <= 5'(`MAX_CURRENT_RST >> 3);
      irq_r          <= 1'b0;
      standby_r      <= 1'b0;
      rdata_r        <= 32'h0000_0000;
    end else begin
      if (load_valid) begin
        load_val_r <= load_calc;
      end
      load_new_r <= load_valid;
      cur_r      <= cur_nxt;
      down_cnt_r <= down_cnt_nxt;
      ps_r       <= ps_nxt;
      status_r   <= status_nxt; // set wins over write-one clear
      stop_req_r <= |(status_nxt & stop_bits);
      motor_cs_r <= (ps_nxt == PS_STANDBY) ? stby_cur_r[7:3] : cur_nxt;
      irq_r      <= |(status_nxt & mask_r);
      standby_r  <= (ps_nxt == PS_STANDBY);
      rdata_r    <= bus.rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign rdata          = rdata_r;
  assign stop_req       = stop_req_r;
  assign motor_cs       = motor_cs_r;
  assign standby_active = standby_r;
  assign irq            = irq_r;

  // ==========================================================
  // checks
  a_fullstep_reset: assert property (@(posedge mclk)
    $past(!rst_n) && rst_n |-> fullsteps_r == `FULLSTEPS_RST && mstep_res_r == `MSTEP_RES_RST)
    else $error("full step or microstep reset value wrong");

  a_ref_clear_pos: assert property (@(posedge mclk) disable iff (!rst_n)
    ref_done && !wr_pos_w |=> enc_pos == 32'h0000_0000)
    else $error("encoder position not cleared after reference done");

  a_index_clear_pos: assert property (@(posedge mclk) disable iff (!rst_n)
    index_hit && enc_func_r[`ENC_FUNC_CLR_INDEX] && !wr_pos_w && !ref_done
      |=> enc_pos == 32'h0000_0000)
    else $error("encoder position not cleared on index");

  a_dev_stop_out: assert property (@(posedge mclk) disable iff (!rst_n)
    dev_exceed |=> stop_req_r && status_r[`ST_DEV])
    else $error("deviation did not stop motor");

  a_stall_stop_out: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(status_r[`ST_STALL]) |-> $past(fast_stall) && $past(load_val_r) == 10'h000 ##0 stop_req_r)
    else $error("stall stop without fast speed and zero load");

  a_load_linear: assert property (@(posedge mclk) disable iff (!rst_n)
    load_valid && load_lag < `LOAD_MAX |=> load_val_r == `LOAD_MAX - $past(load_lag))
    else $error("load value not linear in lag");

  a_slow_full_cur: assert property (@(posedge mclk) disable iff (!rst_n)
    !fast_adapt |=> cur_r == $past(cs_w))
    else $error("current regulated below threshold speed");

  a_cur_window: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> cur_r <= $past(cs_w) && cur_r >= $past(min_w))
    else $error("regulated current out of window");

  a_up_step_size: assert property (@(posedge mclk) disable iff (!rst_n)
    fast_adapt && load_new_r && below_lo && cur_up <= {1'b0, cs_w} && cur_up[4:0] >= min_w
      |=> cur_r == $past(cur_up[4:0]))
    else $error("current up step wrong");

  a_standby_entry: assert property (@(posedge mclk) disable iff (!rst_n)
    ps_r == PS_WAIT && ps_nxt == PS_STANDBY |-> pd_units_r >= pd_delay_r ##1 standby_active)
    else $error("standby entered before delay");

endmodule

`default_nettype wire

// ---- stepper_load_current_supervisor_tb.sv ----
// self-checking bench of the stepper load and current supervisor
`include "stepper_params.svh"
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// bench top
module stepper_load_current_supervisor_tb
  import stepper_pkg::*;
;
  logic        mclk = 1'b0, rst_n = 1'b0, fwd = 1'b0, idx = 1'b0;
  logic        load_valid = 1'b0, ref_done = 1'b0;
  regbus_req_t bus = '0;
  logic [31:0] rdata, motor_pos = 32'h0, vel_pps = 32'h1, vel_int = 32'h1;
  logic [9:0]  load_lag = 10'h0;
  enc_pins_t   enc;
  logic        stop_req, standby_active, irq;
  logic [4:0]  motor_cs;
  int          err_total = 0, n_compared = 0;
  int          nr[4] = '{32, 8, 2, 1};

  // 250 MHz clock
  always #2 mclk = ~mclk;

  quad_enc_model i_quad_enc_model (.mclk(mclk), .fwd(fwd), .idx(idx), .pins(enc));
  stepper_load_current_supervisor #(.PD_UNIT_CYCLES(32'h0000_0004))
    i_stepper_load_current_supervisor (.mclk(mclk), .rst_n(rst_n), .bus(bus),
    .rdata(rdata), .enc(enc), .motor_pos(motor_pos), .vel_pps(vel_pps),
    .vel_int(vel_int), .load_lag(load_lag), .load_valid(load_valid),
    .ref_done(ref_done), .stop_req(stop_req), .motor_cs(motor_cs),
    .standby_active(standby_active), .irq(irq));

  // ==========================================================
  // access and compare tasks
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task flag(input logic f, input logic e);
    chk({31'h0, f}, {31'h0, e});
  endtask
  task cs(input logic [4:0] e);
    chk({27'h0, motor_cs}, {27'h0, e});
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{a, d, 1'b1, 1'b0};
    tick(1);
    bus.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    tick(1);
    bus.rd <= 1'b0;
    chk(rdata, e);
  endtask
  // n load measurements of one lag value
  task pulse(input logic [9:0] lag, input int n);
    repeat (n) begin
      @(posedge mclk);
      load_lag <= lag;
      load_valid <= 1'b1;
      @(posedge mclk);
      load_valid <= 1'b0;
    end
    tick(3);
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    report_and_stop;
  end

  // ==========================================================
  // test sequence
  initial begin
    tick(4);
    flag(stop_req | standby_active | irq, 1'b0);
    cs(5'h10);
    rst_n <= 1'b1;
    rd(`ADDR_FULLSTEPS, 32'h0000_00C8);
    rd(`ADDR_MSTEP_RES, 32'h0000_0008);
    rd(`ADDR_UNIT_MODE, 32'h0000_0001);
    rd(`ADDR_PD_DELAY, 32'h0000_00C8);
    rd(`ADDR_LOAD_VALUE, 32'h0000_03FF);
    rd(8'h00, 32'h0);
    // 51200 per count over 12800 gives four microsteps
    wr(`ADDR_ENC_RES, 32'h0000_3200);
    wr(`ADDR_ENC_POS, 32'h0);
    repeat (3) begin
      @(posedge mclk);
      fwd <= 1'b1;
      @(posedge mclk);
      fwd <= 1'b0;
      tick(8);
    end
    rd(`ADDR_ENC_POS, 32'h0000_000C);
    wr(`ADDR_MAX_DEV, 32'h3);
    tick(2);
    flag(stop_req, 1'b1);
    rd(`ADDR_STATUS, 32'h2);
    wr(`ADDR_MAX_DEV, 32'h0);
    wr(`ADDR_STATUS, 32'h2);
    tick(2);
    flag(stop_req, 1'b0);
    wr(`ADDR_ENC_POS, 32'h64);
    rd(`ADDR_ENC_POS, 32'h64);
    @(posedge mclk);
    ref_done <= 1'b1;
    @(posedge mclk);
    ref_done <= 1'b0;
    tick(2);
    rd(`ADDR_ENC_POS, 32'h0);
    wr(`ADDR_ENC_FUNC, 32'h1);
    wr(`ADDR_ENC_POS, 32'h5);
    @(posedge mclk);
    idx <= 1'b1;
    tick(6);
    rd(`ADDR_ENC_POS, 32'h0);
    rd(`ADDR_STATUS, 32'hC);
    wr(`ADDR_STATUS, 32'hF);
    // one encoder revolution at one microstep per full step: software sees 200 per rev
    wr(`ADDR_MSTEP_RES, 32'h0);
    wr(`ADDR_ENC_RES, 32'h4);
    repeat (4) begin
      @(posedge mclk);
      fwd <= 1'b1;
      @(posedge mclk);
      fwd <= 1'b0;
      tick(52);
    end
    rd(`ADDR_ENC_POS, 32'h0000_00C8);
    // stall stop only above its speed
    wr(`ADDR_STALL_SPEED, 32'h64);
    vel_pps <= 32'h32;
    pulse(10'h3FF, 1);
    flag(stop_req, 1'b0);
    rd(`ADDR_LOAD_VALUE, 32'h0);
    vel_pps <= 32'hC8;
    pulse(10'h3FF, 1);
    flag(stop_req, 1'b1);
    rd(`ADDR_STATUS, 32'h1);
    wr(`ADDR_STALL_SPEED, 32'h0);
    wr(`ADDR_STATUS, 32'h1);
    // adaptive current: lower 100, upper 200
    wr(`ADDR_MAX_CURRENT, 32'hFF);
    wr(`ADDR_LOAD_LOWER, 32'h64);
    wr(`ADDR_HYST, 32'h64);
    wr(`ADDR_ADAPT_SPEED, 32'h64);
    vel_pps <= 32'h32;
    tick(3);
    cs(5'h1F);
    vel_pps <= 32'hC8;
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_DOWN_STEP, 32'(3 - i));
      pulse(10'h000, nr[3 - i] - 1);
      cs(5'(31 - i));
      pulse(10'h000, 1);
      cs(5'(30 - i));
    end
    // one reading per decrement so each round falls to the half floor quickly
    wr(`ADDR_DOWN_STEP, 32'h3);
    for (int u = 0; u < 4; u++) begin
      wr(`ADDR_UP_STEP, 32'(u));
      pulse(10'h000, 16);
      cs(5'hF);
      pulse(10'h3CD, 1);
      cs(5'(15 + (1 << u)));
    end
    pulse(10'h3CD, 2);
    cs(5'h1F);
    pulse(10'h369, 3);
    cs(5'h1F);
    wr(`ADDR_ADAPT_MIN, 32'h1);
    pulse(10'h000, 28);
    cs(5'h7);
    // standstill in internal units only, two units of four cycles
    wr(`ADDR_PD_DELAY, 32'h2);
    wr(`ADDR_MASK, 32'h10);
    wr(`ADDR_UNIT_MODE, 32'h0);
    vel_int <= 32'h0;
    tick(4);
    flag(standby_active, 1'b0);
    tick(20);
    flag(standby_active, 1'b1);
    cs(5'h4);
    flag(irq, 1'b1);
    wr(`ADDR_STATUS, 32'h10);
    tick(2);
    flag(irq, 1'b0);
    vel_int <= 32'h1;
    tick(2);
    flag(standby_active, 1'b0);
    report_and_stop;
  end
endmodule
`default_nettype wire

// ---- stepper_params.svh ----
// constants of the stepper load and current supervisor: offsets, fields, resets, timing
`ifndef STEPPER_PARAMS_SVH
`define STEPPER_PARAMS_SVH

// ==========================================================
// register offsets (address port value)
`define ADDR_MAX_CURRENT     8'h10
`define ADDR_STANDBY_CURRENT 8'h11
`define ADDR_MSTEP_RES       8'h8C
`define ADDR_ADAPT_MIN       8'hA8
`define ADDR_DOWN_STEP       8'hA9
`define ADDR_HYST            8'hAA
`define ADDR_UP_STEP         8'hAB
`define ADDR_STALL_SPEED     8'hB5
`define ADDR_ADAPT_SPEED     8'hB6
`define ADDR_ENC_FUNC        8'hC9
`define ADDR_FULLSTEPS       8'hCA
`define ADDR_ENC_POS         8'hD1
`define ADDR_ENC_RES         8'hD2
`define ADDR_MAX_DEV         8'hD4
`define ADDR_PD_DELAY        8'hD6
`define ADDR_LOAD_LOWER      8'hE0
`define ADDR_STATUS          8'hE1
`define ADDR_MASK            8'hE2
`define ADDR_LOAD_VALUE      8'hE3
`define ADDR_CUR_SCALE       8'hE4
`define ADDR_UNIT_MODE       8'hFF

// ==========================================================
// reset values and microstep resolution clamp
`define FULLSTEPS_RST        16'h00C8
`define MSTEP_RES_RST        4'h8
`define MSTEP_RES_MAX        4'h8
`define UNIT_MODE_RST        1'h1
`define PD_DELAY_RST         16'h00C8
`define ENC_RES_RST          16'h0190
`define MAX_CURRENT_RST      8'h80
`define STANDBY_CURRENT_RST  8'h20

// ==========================================================
// status and mask bit positions
`define ST_STALL             0
`define ST_DEV               1
`define ST_INDEX             2
`define ST_REFCLR            3
`define ST_STANDBY           4
`define ST_W                 5

// encoder function bit: clear position on index channel
`define ENC_FUNC_CLR_INDEX   0

// ==========================================================
// load measurement scale
`define LOAD_W               10
`define LOAD_MAX             10'h3FF

// ==========================================================
// timing
`define CLK_PERIOD_PS        64'h0000_0FA0
`define PD_UNIT_MS           64'h0000_000A
`define PS_PER_MS            64'h3B9A_CA00
`define PD_UNIT_CYCLES       ((`PD_UNIT_MS * `PS_PER_MS) / `CLK_PERIOD_PS)

`endif

// ---- stepper_pkg.sv ----
// types shared by the stepper load and current supervisor files
package stepper_pkg;

  // ==========================================================
  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } regbus_req_t;

  // incremental encoder pins
  typedef struct packed {
    logic a;
    logic b;
    logic n;
  } enc_pins_t;

  // current power state
  typedef enum logic [1:0] {
    PS_RUN     = 2'b00,
    PS_WAIT    = 2'b01,
    PS_STANDBY = 2'b10
  } power_state_t;

endpackage
